/* common/rwa_pkg.sv */
// Shared constants, register map and types of the receive word aligner status block.
package rwa_pkg;
   localparam int unsigned WORD_W   = 10;
   localparam int unsigned BND_W    = 4;
   localparam int unsigned RUN_W    = 8;
   localparam int unsigned INT_W    = 5;
   localparam int unsigned PC_DEPTH = 2;

   // Run-length hold in parallel clock cycles; lock count in received patterns.
   localparam logic [1:0] RLV_HOLD      = 2'h3;
   localparam logic [1:0] LOCK_PATTERNS = 2'h3;

   // Register byte offsets.
   localparam logic [7:0] OFS_CTRL       = 8'h00;
   localparam logic [7:0] OFS_PATTERN    = 8'h04;
   localparam logic [7:0] OFS_RLV_THR    = 8'h08;
   localparam logic [7:0] OFS_STATUS     = 8'h0C;
   localparam logic [7:0] OFS_INT_STATUS = 8'h10;
   localparam logic [7:0] OFS_INT_MASK   = 8'h14;

   // Field positions.
   localparam int unsigned STAT_SYNC_BIT = 0;
   localparam int unsigned STAT_PAT_BIT  = 1;
   localparam int unsigned STAT_BND_LSB  = 2;
   localparam int unsigned INT_GAIN_BIT  = 0;
   localparam int unsigned INT_LOSS_BIT  = 1;
   localparam int unsigned INT_RLV_BIT   = 2;
   localparam int unsigned INT_INS_BIT   = 3;
   localparam int unsigned INT_DEL_BIT   = 4;

   // Reset values.
   localparam logic [1:0]  CTRL_RST     = 2'h0;
   localparam logic [9:0]  PATTERN_RST  = 10'h17C;
   localparam logic [7:0]  RLV_THR_RST  = 8'h14;
   localparam logic [4:0]  INT_MASK_RST = 5'h00;

   typedef enum logic [1:0] {
      RWA_MODE_AUTO   = 2'h0,
      RWA_MODE_MANUAL = 2'h1,
      RWA_MODE_SLIP   = 2'h2
   } rwa_mode_t;

   typedef struct packed {
      logic [WORD_W-1:0] data;
      logic              sync;
      logic              pattern;
      logic              rmInsert;
      logic              rmDelete;
   } rwa_lane_t;

   typedef struct packed {
      logic [7:0]  addr;
      logic [31:0] wrData;
      logic        wrStb;
      logic        rdStb;
   } rwa_bus_req_t;
endpackage

/* hdl/rwa_phase_pipe.sv */
// Phase compensation stage carrying aligned words and their status flags together.
`timescale 1ns/100ps
module rwa_phase_pipe (
   // Clock and reset
   input  wire logic          ref_clk,
   input  wire logic          arst_n,
   // Lane
   input  wire rwa_pkg::rwa_lane_t laneIn,
   output var  rwa_pkg::rwa_lane_t laneOut
);
   import rwa_pkg::*;

   rwa_lane_t stage_q [PC_DEPTH];

   // Flags travel in the same stages as the data so they never drift apart.
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         for (int i = 0; i < PC_DEPTH; i++) stage_q[i] <= '0;
      end else begin
         stage_q[0] <= laneIn;
         for (int i = 1; i < PC_DEPTH; i++) stage_q[i] <= stage_q[i-1];
      end
   end

   assign laneOut = stage_q[PC_DEPTH-1];
endmodule // rwa_phase_pipe

/* hdl/rwa_align_status.sv */
// Receive word aligner with lock, pattern, run-length and rate match status.
//
// Chosen here: the address map and strobed register access.
`timescale 1ns/100ps
// Operation
// - An alignment lock output shows whether the aligner is synchronised to the stream.
// - In bit-slip mode the alignment lock output is held low.
// - The pattern found output is high when the programmed pattern sits at the current boundary.
// - Lock and pattern found travel through the phase compensation stage alongside the data.
// - In bit-slip mode each rising edge of the slip request moves the boundary by one bit.
// - While polarity inversion is high every bit of the incoming word is inverted.
// - A run-length violation pulse marks a run of equal bits above the programmed threshold.
// - The run-length violation pulse stands for at least three parallel cycles.
// - In manual mode the manual alignment enable decides whether the boundary may move.
// - The insertion flag is high when the rate match FIFO inserts a pattern byte.
// - The deletion flag is high when the rate match FIFO removes a pattern byte.
module rwa_align_status (
   // Clock and reset
   input  wire logic                     ref_clk,
   input  wire logic                     arst_n,
   // Register port
   input  wire rwa_pkg::rwa_bus_req_t    busReq,
   output var  logic [31:0]              busRdData,
   // Receive stream and controls
   input  wire logic [rwa_pkg::WORD_W-1:0] rxWord,
   input  wire logic                     polarityInvertAsync,
   input  wire logic                     bitSlipReqAsync,
   input  wire logic                     manualAlignEnableAsync,
   // Rate match FIFO events
   input  wire logic                     rateInsertEvt,
   input  wire logic                     rateDeleteEvt,
   // Status to the core
   output var  logic [rwa_pkg::WORD_W-1:0] alignedWord,
   output var  logic                     alignLock,
   output var  logic                     alignPatternFound,
   output var  logic                     runLengthViolation,
   output var  logic                     rateFifoInsertFlag,
   output var  logic                     rateFifoDeleteFlag,
   output var  logic                     irq
);
   import rwa_pkg::*;

   typedef enum logic [1:0] {ST_LOSS, ST_ACQ, ST_SYNC} rwa_state_t;

   function automatic logic [4:0] findPattern(input logic [19:0] win, input logic [9:0] pat);
      logic [4:0] res;
      res = '0;
      for (int i = 9; i >= 0; i--) begin
         if (win[i +: 10] == pat) res = {1'b1, 4'(i)};
      end
      return res;
   endfunction

   function automatic logic [16:0] runScan(input logic [9:0] w, input logic lastIn,
                                           input logic [7:0] runIn);
      logic       last;
      logic [7:0] run;
      logic [7:0] mx;
      last = lastIn;
      run  = runIn;
      mx   = runIn;
      for (int i = 0; i < 10; i++) begin
         if (w[i] == last) begin
            if (run != 8'hFF) run = run + 8'h01;
         end else begin
            run  = 8'h01;
            last = w[i];
         end
         if (run > mx) mx = run;
      end
      return {mx, last, run};
   endfunction

   // Asynchronous controls: first stage feeds only the second.
   logic [2:0]        meta_q;
   logic [2:0]        syncd_q;
   logic              slipPrev_q;
   logic [1:0]        ctrl_q;
   logic [9:0]        pattern_q;
   logic [7:0]        rlvThr_q;
   logic [4:0]        intMask_q;
   logic [4:0]        intSt_q;
   logic [4:0]        intSt_d;
   logic [31:0]       rdData_q;
   logic [9:0]        prevWord_q;
   logic [3:0]        boundary_q;
   logic [3:0]        boundary_d;
   logic [1:0]        patCnt_q;
   logic [1:0]        patCnt_d;
   rwa_state_t        state_q;
   rwa_state_t        state_d;
   logic              runBit_q;
   logic [7:0]        runLen_q;
   logic [1:0]        rlvCnt_q;
   logic [1:0]        rlvCnt_d;
   rwa_lane_t         laneIn;
   rwa_lane_t         laneOut;

   wire        polInv    = syncd_q[2];
   wire        slipLvl   = syncd_q[1];
   wire        manEn     = syncd_q[0];
   wire        slipRise  = slipLvl && !slipPrev_q;
   wire        isSlip    = ctrl_q == RWA_MODE_SLIP;
   wire        isManual  = ctrl_q == RWA_MODE_MANUAL;
   wire        realignOk = isManual ? manEn : 1'b1;
   wire [9:0]  invWord   = polInv ? ~rxWord : rxWord;
   wire [19:0] window    = {invWord, prevWord_q};
   wire [9:0]  alignedNow = window[boundary_q +: 10];
   wire        patHere   = alignedNow == pattern_q;
   wire [4:0]  search    = findPattern(window, pattern_q);
   wire        patAny    = search[4];
   wire [3:0]  patOff    = search[3:0];
   wire        patElse   = patAny && !patHere;
   wire        syncNow   = (state_q == ST_SYNC) && !isSlip;
   wire [16:0] scan      = runScan(invWord, runBit_q, runLen_q);
   wire        rlvHit    = scan[16:9] > rlvThr_q;
   wire        evGain    = (state_q != ST_SYNC) && (state_d == ST_SYNC);
   wire        evLoss    = (state_q == ST_SYNC) && (state_d != ST_SYNC);
   wire [4:0]  events    = {rateDeleteEvt, rateInsertEvt, rlvHit && (rlvCnt_q == 2'h0),
                            evLoss, evGain};
   wire        wrCtrl    = busReq.wrStb && (busReq.addr == OFS_CTRL);
   wire        wrPat     = busReq.wrStb && (busReq.addr == OFS_PATTERN);
   wire        wrThr     = busReq.wrStb && (busReq.addr == OFS_RLV_THR);
   wire        wrMask    = busReq.wrStb && (busReq.addr == OFS_INT_MASK);
   wire        rdIntSt   = busReq.rdStb && (busReq.addr == OFS_INT_STATUS);
   wire [31:0] statusWord = {26'h0, boundary_q, alignPatternFound, alignLock};
   wire [31:0] rdMux =
      (busReq.addr == OFS_CTRL)       ? {30'h0, ctrl_q}    :
      (busReq.addr == OFS_PATTERN)    ? {22'h0, pattern_q} :
      (busReq.addr == OFS_RLV_THR)    ? {24'h0, rlvThr_q}  :
      (busReq.addr == OFS_STATUS)     ? statusWord         :
      (busReq.addr == OFS_INT_STATUS) ? {27'h0, intSt_q}   :
      (busReq.addr == OFS_INT_MASK)   ? {27'h0, intMask_q} : 32'h0;

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         meta_q     <= 3'h0;
         syncd_q    <= 3'h0;
         slipPrev_q <= 1'b0;
      end else begin
         meta_q     <= {polarityInvertAsync, bitSlipReqAsync, manualAlignEnableAsync};
         syncd_q    <= meta_q;
         slipPrev_q <= slipLvl;
      end
   end

   // Boundary search and lock tracking.
   always_comb begin
      state_d    = state_q;
      boundary_d = boundary_q;
      patCnt_d   = patCnt_q;
      if (isSlip) begin
         state_d  = ST_LOSS;
         patCnt_d = 2'h0;
         if (slipRise) boundary_d = (boundary_q == 4'h9) ? 4'h0 : boundary_q + 4'h1;
      end else begin
         unique case (state_q)
            ST_LOSS: begin
               if (patAny && realignOk) begin
                  boundary_d = patOff;
                  patCnt_d   = 2'h1;
                  state_d    = ST_ACQ;
               end
            end
            ST_ACQ: begin
               if (patHere) begin
                  patCnt_d = patCnt_q + 2'h1;
                  if (patCnt_q + 2'h1 == LOCK_PATTERNS) state_d = ST_SYNC;
               end else if (patElse && realignOk) begin
                  boundary_d = patOff;
                  patCnt_d   = 2'h1;
               end
            end
            ST_SYNC: begin
               if (patElse) begin
                  state_d  = ST_LOSS;
                  patCnt_d = 2'h0;
               end
            end
         endcase
      end
   end

   // The violation is stretched so slower core logic cannot miss it.
   assign rlvCnt_d = rlvHit ? RLV_HOLD : ((rlvCnt_q != 2'h0) ? rlvCnt_q - 2'h1 : 2'h0);

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         state_q    <= ST_LOSS;
         boundary_q <= 4'h0;
         patCnt_q   <= 2'h0;
         prevWord_q <= 10'h000;
         runBit_q   <= 1'b0;
         runLen_q   <= 8'h00;
         rlvCnt_q   <= 2'h0;
      end else begin
         state_q    <= state_d;
         boundary_q <= boundary_d;
         patCnt_q   <= patCnt_d;
         prevWord_q <= invWord;
         runBit_q   <= scan[8];
         runLen_q   <= scan[7:0];
         rlvCnt_q   <= rlvCnt_d;
      end
   end

   assign laneIn = '{data: alignedNow, sync: syncNow, pattern: patHere,
                     rmInsert: rateInsertEvt, rmDelete: rateDeleteEvt};

   rwa_phase_pipe u_pipe (
      .ref_clk (ref_clk),
      .arst_n  (arst_n),
      .laneIn  (laneIn),
      .laneOut (laneOut)
   );

   // Every status leaves on the block's single parallel clock.
   assign alignedWord        = laneOut.data;
   assign alignLock          = laneOut.sync;
   assign alignPatternFound  = laneOut.pattern;
   assign rateFifoInsertFlag = laneOut.rmInsert;
   assign rateFifoDeleteFlag = laneOut.rmDelete;
   assign runLengthViolation = rlvCnt_q != 2'h0;

   // Reading the interrupt status clears it, but a same-cycle event still lands.
   assign intSt_d = (rdIntSt ? 5'h00 : intSt_q) | events;

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         ctrl_q    <= CTRL_RST;
         pattern_q <= PATTERN_RST;
         rlvThr_q  <= RLV_THR_RST;
         intMask_q <= INT_MASK_RST;
         intSt_q   <= 5'h00;
         rdData_q  <= 32'h0;
      end else begin
         if (wrCtrl) ctrl_q <= busReq.wrData[1:0];
         if (wrPat) pattern_q <= busReq.wrData[9:0];
         if (wrThr) rlvThr_q <= busReq.wrData[7:0];
         if (wrMask) intMask_q <= busReq.wrData[4:0];
         intSt_q  <= intSt_d;
         rdData_q <= busReq.rdStb ? rdMux : 32'h0;
      end
   end

   assign busRdData = rdData_q;
   assign irq       = |(intSt_q & intMask_q);

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!arst_n);

   chk_slip_no_lock: assert property (isSlip |-> ##2 !alignLock)
      else $error("lock shown in bit-slip mode");
   chk_slip_step: assert property (isSlip && slipRise |=>
      boundary_q == (($past(boundary_q) == 4'h9) ? 4'h0 : $past(boundary_q) + 4'h1))
      else $error("bit-slip did not move boundary by one");
   chk_pol_invert: assert property (polInv |=> prevWord_q == ~$past(rxWord))
      else $error("inverted word not taken");
   chk_rlv_cause: assert property (rlvHit |=> runLengthViolation)
      else $error("run-length hit not flagged");
   chk_rlv_hold: assert property ($rose(runLengthViolation) |-> runLengthViolation [*3])
      else $error("run-length pulse too short");
   chk_lock_path: assert property (alignLock == $past(syncNow, 2))
      else $error("lock not aligned with data path");
   chk_pattern_path: assert property (alignPatternFound == $past(patHere, 2))
      else $error("pattern flag not aligned with data");
   chk_manual_hold: assert property (isManual && !manEn && state_q != ST_SYNC && !patHere
      |=> $stable(boundary_q))
      else $error("boundary moved while manual align disabled");
   chk_lock_state: assert property (state_q == ST_SYNC && !isSlip |-> ##2 alignLock)
      else $error("lock missing in sync state");
   chk_insert_flag: assert property (rateInsertEvt |-> ##2 rateFifoInsertFlag)
      else $error("insert flag missing");
   chk_delete_flag: assert property (rateDeleteEvt |-> ##2 rateFifoDeleteFlag)
      else $error("delete flag missing");

   cov_lock_reached: cover property (state_q == ST_ACQ ##1 state_q == ST_SYNC);
   cov_slip_step: cover property (isSlip && slipRise);
   cov_rlv_pulse: cover property ($rose(runLengthViolation));
endmodule // rwa_align_status

/* test/rwa_core_model.sv */
// Core-side model that feeds the receive stream and holds the inversion control.
`timescale 1ns/100ps
module rwa_core_model (
   // Clock and reset
   input  wire logic                       ref_clk,
   input  wire logic                       arst_n,
   // Commands from the bench
   input  wire logic [3:0]                 symOffset,
   input  wire logic                       zeroFill,
   input  wire logic                       invertCmd,
   // Lines into the block
   output var  logic [rwa_pkg::WORD_W-1:0] rxWord,
   output var  logic                       polarityInvertAsync
);
   import rwa_pkg::*;
   logic [1:0]        hold_q;
   logic [19:0]       dblWord;
   logic [WORD_W-1:0] baseWord;
   // The pattern is rotated so that it sits at symOffset inside the two-word window.
   assign dblWord  = {PATTERN_RST, PATTERN_RST} << symOffset;
   assign baseWord = zeroFill ? '0 : dblWord[19:10];
   // A new inversion level waits out the hold, so no pulse is shorter than three cycles.
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         polarityInvertAsync <= 1'b0;
         hold_q              <= 2'h0;
      end else if (hold_q != 2'h0) begin
         hold_q <= hold_q - 2'h1;
      end else if (invertCmd != polarityInvertAsync) begin
         polarityInvertAsync <= invertCmd;
         hold_q              <= 2'h2;
      end
   end
   // The line is flipped upstream; the block is expected to undo it.
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         rxWord <= '0;
      end else begin
         rxWord <= baseWord ^ {WORD_W{polarityInvertAsync}};
      end
   end
endmodule // rwa_core_model

/* test/rwa_align_status_bench.sv */
// Self-checking bench for the receive word aligner status block.
`timescale 1ns/100ps
module rwa_align_status_bench;
   import rwa_pkg::*;
   logic              ref_clk;
   logic              arst_n;
   rwa_bus_req_t      busReq;
   logic [31:0]       busRdData;
   logic [31:0]       rdVal;
   logic [WORD_W-1:0] rxWord;
   logic [WORD_W-1:0] alignedWord;
   logic              polarityInvertAsync;
   logic              bitSlipReqAsync;
   logic              manualAlignEnableAsync;
   logic              rateInsertEvt;
   logic              rateDeleteEvt;
   logic              alignLock;
   logic              alignPatternFound;
   logic              runLengthViolation;
   logic              rateFifoInsertFlag;
   logic              rateFifoDeleteFlag;
   logic              irq;
   logic [3:0]        symOffset;
   logic              zeroFill;
   logic              invertCmd;
   int                failCount;
   int                checked;
   int                runLen;

   rwa_align_status dut_u (.ref_clk(ref_clk), .arst_n(arst_n), .busReq(busReq),
      .busRdData(busRdData), .rxWord(rxWord), .polarityInvertAsync(polarityInvertAsync),
      .bitSlipReqAsync(bitSlipReqAsync), .manualAlignEnableAsync(manualAlignEnableAsync),
      .rateInsertEvt(rateInsertEvt), .rateDeleteEvt(rateDeleteEvt),
      .alignedWord(alignedWord), .alignLock(alignLock), .alignPatternFound(alignPatternFound),
      .runLengthViolation(runLengthViolation), .rateFifoInsertFlag(rateFifoInsertFlag),
      .rateFifoDeleteFlag(rateFifoDeleteFlag), .irq(irq));

   rwa_core_model core_u (.ref_clk(ref_clk), .arst_n(arst_n), .symOffset(symOffset),
      .zeroFill(zeroFill), .invertCmd(invertCmd), .rxWord(rxWord),
      .polarityInvertAsync(polarityInvertAsync));

   task automatic conclude();
      $display("Comparisons %0d, mismatches %0d", checked, failCount);
      if (failCount == 0 && checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         failCount++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask

   // Flags are chosen by code so the wait needs no reference argument.
   localparam int SEL_LOCK = 0;
   localparam int SEL_RLV  = 1;
   localparam int SEL_INS  = 2;
   localparam int SEL_DEL  = 3;

   function automatic logic pick(input int sel);
      case (sel)
         SEL_LOCK: return alignLock;
         SEL_RLV:  return runLengthViolation;
         SEL_INS:  return rateFifoInsertFlag;
         default:  return rateFifoDeleteFlag;
      endcase
   endfunction

   // A flag that never comes counts as a mismatch and ends the run.
   task automatic waitHigh(input int sel, input int bound);
      for (int i = 0; i < bound; i++) begin
         if (pick(sel) === 1'b1) return;
         cyc(1);
      end
      check(pick(sel), 1'b1);
      conclude();
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      busReq <= '{addr: a, wrData: d, wrStb: 1'b1, rdStb: 1'b0};
      @(posedge ref_clk);
      busReq.wrStb <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a);
      @(posedge ref_clk);
      busReq <= '{addr: a, wrData: 32'h0, wrStb: 1'b0, rdStb: 1'b1};
      @(posedge ref_clk);
      busReq.rdStb <= 1'b0;
      #1 rdVal = busRdData;
   endtask

   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end

   initial begin
      repeat (20000) @(posedge ref_clk);
      check(32'h0, 32'h1);
      conclude();
   end

   initial begin
      arst_n = 1'b0;
      busReq = '0;
      bitSlipReqAsync = 1'b0;
      manualAlignEnableAsync = 1'b0;
      rateInsertEvt = 1'b0;
      rateDeleteEvt = 1'b0;
      symOffset = 4'h3;
      zeroFill = 1'b0;
      invertCmd = 1'b0;
      failCount = 0;
      checked = 0;
      repeat (3) @(posedge ref_clk);
      arst_n <= 1'b1;
      rd(OFS_PATTERN);
      check(rdVal, 32'(PATTERN_RST));
      rd(OFS_RLV_THR);
      check(rdVal, 32'(RLV_THR_RST));
      rd(8'h20);
      check(rdVal, 32'h0);
      // Automatic alignment onto a pattern three bits into the window.
      waitHigh(SEL_LOCK, 60);
      check(alignPatternFound, 1'b1);
      check(alignedWord, 32'(PATTERN_RST));
      rd(OFS_STATUS);
      check(rdVal, 32'h0F);
      // Manual mode: the boundary stays put until the enable is raised.
      wr(OFS_CTRL, 32'h1);
      symOffset <= 4'h5;
      cyc(20);
      rd(OFS_STATUS);
      check(rdVal[5:2], 32'h3);
      @(posedge ref_clk);
      manualAlignEnableAsync <= 1'b1;
      cyc(2);
      waitHigh(SEL_LOCK, 60);
      rd(OFS_STATUS);
      check(rdVal, 32'h17);
      // Dropping the old boundary and locking on the new one both leave sticky bits.
      rd(OFS_INT_STATUS);
      check(rdVal & 32'h03, 32'h03);
      @(posedge ref_clk);
      manualAlignEnableAsync <= 1'b0;
      // An inverted line must still give the plain pattern.
      wr(OFS_CTRL, 32'h0);
      invertCmd <= 1'b1;
      cyc(30);
      waitHigh(SEL_LOCK, 60);
      check(alignedWord, 32'(PATTERN_RST));
      check(alignPatternFound, 1'b1);
      // Bit-slip mode: no lock, one bit per request, wrapping after the last position.
      wr(OFS_CTRL, 32'h2);
      cyc(6);
      check(alignLock, 1'b0);
      rd(OFS_STATUS);
      check(rdVal[0], 1'b0);
      for (int i = 1; i <= 5; i++) begin
         @(posedge ref_clk);
         bitSlipReqAsync <= 1'b1;
         repeat (3) @(posedge ref_clk);
         bitSlipReqAsync <= 1'b0;
         cyc(4);
         rd(OFS_STATUS);
         check(rdVal[5:2], 32'((5 + i) % 10));
      end
      // Run-length violation with its interrupt unmasked.
      wr(OFS_CTRL, 32'h0);
      wr(OFS_INT_MASK, 32'h04);
      rd(OFS_INT_STATUS);
      @(posedge ref_clk);
      zeroFill <= 1'b1;
      waitHigh(SEL_RLV, 100);
      cyc(2);
      check(irq, 1'b1);
      @(posedge ref_clk);
      zeroFill <= 1'b0;
      #1;
      runLen = 0;
      while (runLengthViolation === 1'b1 && runLen < 60) begin
         runLen++;
         cyc(1);
      end
      check(runLen >= 3, 1'b1);
      rd(OFS_INT_STATUS);
      check(rdVal & 32'h04, 32'h04);
      cyc(1);
      check(irq, 1'b0);
      // Insertion unmasked, deletion masked.
      wr(OFS_INT_MASK, 32'h08);
      rateInsertEvt <= 1'b1;
      @(posedge ref_clk);
      rateInsertEvt <= 1'b0;
      waitHigh(SEL_INS, 4);
      cyc(2);
      check(irq, 1'b1);
      rd(OFS_INT_STATUS);
      check(rdVal & 32'h18, 32'h08);
      cyc(1);
      check(irq, 1'b0);
      @(posedge ref_clk);
      rateDeleteEvt <= 1'b1;
      @(posedge ref_clk);
      rateDeleteEvt <= 1'b0;
      waitHigh(SEL_DEL, 4);
      cyc(2);
      check(irq, 1'b0);
      rd(OFS_INT_STATUS);
      check(rdVal & 32'h18, 32'h10);
      conclude();
   end
endmodule // rwa_align_status_bench
